/* File: verilog/rcts_pkg.sv */
`default_nettype none
package rcts_pkg;
	// Clocking: unit clock and sequencer reference rate
	localparam int CLK_MHZ  = 200;
	localparam int REF_MHZ  = 50;
	localparam int TICK_DIV = CLK_MHZ / REF_MHZ;

	// Register byte addresses
	localparam logic [7:0] ADDR_CTRL     = 8'h00;
	localparam logic [7:0] ADDR_STATUS   = 8'h04;
	localparam logic [7:0] ADDR_INT_STAT = 8'h08;
	localparam logic [7:0] ADDR_INT_MASK = 8'h0C;
	localparam logic [7:0] ADDR_OUT_WORD = 8'h10;

	// Control register bits (write-only strobes)
	localparam int CTRL_START  = 0;
	localparam int CTRL_RESET  = 1;
	localparam int CTRL_LOADED = 2;

	// Status register bits
	localparam int STS_STOPPED = 0;
	localparam int STS_RESET_N = 1;
	localparam int STS_RUNNING = 2;
	localparam int STS_WAITING = 3;
	localparam int STS_TRIG    = 4;
	localparam int STS_HALT    = 5;

	// Interrupt event bits
	localparam int EVT_W     = 4;
	localparam int EVT_STOP  = 0;
	localparam int EVT_WAIT  = 1;
	localparam int EVT_HALT  = 2;
	localparam int EVT_START = 3;
	localparam logic [EVT_W-1:0] INT_MASK_RST = 4'h0;

	localparam int WORD_W   = 24;
	localparam int LOW_BITS = 4;
	localparam logic [WORD_W-1:0] WORD_RST = 24'h00_0000;

	typedef enum logic [2:0] {
		ST_RESET,
		ST_HALTED,
		ST_RUNNING,
		ST_WAITING,
		ST_STOPPED
	} rcts_state_type;
endpackage
`default_nettype wire

/* File: verilog/rcts_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module rcts_sync #(
	parameter logic IDLE_LVL = 1'b1
) (
	input  wire logic mclk,      // Unit clock
	input  wire logic rst_b,     // Synchronous reset, low
	input  wire logic pin_in,    // Asynchronous pin
	output logic      level_ff,  // Filtered level
	output logic      fall_ff    // One-cycle pulse on falling change
);
	logic s1_ff;
	logic s2_ff;
	logic s3_ff;
	wire  agree = (s2_ff == s3_ff);

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			s1_ff    <= IDLE_LVL;
			s2_ff    <= IDLE_LVL;
			s3_ff    <= IDLE_LVL;
			level_ff <= IDLE_LVL;
			fall_ff  <= 1'b0;
		end else begin
			s1_ff    <= pin_in;
			s2_ff    <= s1_ff;
			s3_ff    <= s2_ff;
			level_ff <= agree ? s3_ff : level_ff;
			fall_ff  <= agree & level_ff & ~s3_ff;
		end
	end
endmodule
`default_nettype wire

/* File: verilog/rcts_tick.sv */
`timescale 1ns/1ps
`default_nettype none
module rcts_tick #(
	parameter int DIV = rcts_pkg::TICK_DIV
) (
	input  wire logic mclk,     // Unit clock
	input  wire logic rst_b,    // Synchronous reset, low
	output logic      tick_ff   // One pulse every DIV cycles
);
	localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
	localparam logic [CW-1:0] LAST = CW'(DIV - 1);
	logic [CW-1:0] cnt_ff;
	wire           wrap = (cnt_ff == LAST);

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			cnt_ff  <= '0;
			tick_ff <= 1'b0;
		end else begin
			cnt_ff  <= wrap ? '0 : cnt_ff + 1'b1;
			tick_ff <= wrap;
		end
	end
endmodule
`default_nettype wire

/* File: verilog/rcts_top.sv */
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Stopped output high after stop reached
// - Reset output low in reset state
// - Running high only while program executes
// - Waiting high after wait until trigger
// - Active-low trigger falling edge starts idle program
// - Trigger after wait resumes next instruction
// - Trigger after stop or halt restarts
// - Active-low halt input stops execution
// - Halt while running rewinds to first instruction
// - After halt, software or trigger restarts
// - Low four word bits on dedicated outputs
// - 50 MHz reference tick divided from the 200 MHz clock
// - Word bits constant through each instruction
module rcts_top #(
	parameter int WORD_W = rcts_pkg::WORD_W
) (
	input  wire logic              mclk,                  // 200 MHz clock
	input  wire logic              rst_b,                 // Synchronous reset, low
	input  wire logic              external_start_in_n,   // Trigger pin, low active
	input  wire logic              external_halt_in_n,    // Halt pin, low active
	input  wire logic              psel,                  // APB select
	input  wire logic              penable,               // APB enable
	input  wire logic              pwrite,                // APB direction
	input  wire logic [7:0]        paddr,                 // APB byte address
	input  wire logic [31:0]       pwdata,                // APB write data
	output logic      [31:0]       prdata,                // APB read data
	output logic                   pready,                // APB ready
	output logic                   pslverr,               // APB error
	output logic                   irq,                   // Level interrupt
	input  wire logic              seq_stop_hit,          // Core reached stop
	input  wire logic              seq_wait_hit,          // Core reached wait
	input  wire logic              seq_word_load,         // Core starts new instruction
	input  wire logic [WORD_W-1:0] seq_word,              // Word of that instruction
	output logic                   seq_tick,              // 50 MHz reference enable
	output logic                   seq_run,               // Core may execute
	output logic                   seq_restart,           // Pulse: go to first instruction
	output logic                   seq_resume,            // Pulse: continue after wait
	output logic [WORD_W-1:0]      output_bits,           // Held output word
	output logic [3:0]             output_bits_low_group, // Bits 3..0 to dedicated outputs
	output logic                   status_stopped,        // High when stopped
	output logic                   status_reset_n,        // Low in reset state
	output logic                   status_running,        // High while running
	output logic                   status_waiting         // High while waiting
);
	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers and reference tick
	logic trig_lvl;
	logic trig_fall;
	logic halt_lvl;
	logic halt_fall;

	rcts_sync #(.IDLE_LVL(1'b1)) u_trig (
		.mclk     (mclk),
		.rst_b    (rst_b),
		.pin_in   (external_start_in_n),
		.level_ff (trig_lvl),
		.fall_ff  (trig_fall)
	);

	rcts_sync #(.IDLE_LVL(1'b1)) u_halt (
		.mclk     (mclk),
		.rst_b    (rst_b),
		.pin_in   (external_halt_in_n),
		.level_ff (halt_lvl),
		.fall_ff  (halt_fall)
	);

	rcts_tick #(.DIV(rcts_pkg::TICK_DIV)) u_tick (
		.mclk    (mclk),
		.rst_b   (rst_b),
		.tick_ff (seq_tick)
	);

	////////////////////////////////////////////////////////////////////////////////
	// APB decode
	wire acc     = psel & penable & pready;
	wire wr_acc  = acc & pwrite;
	wire a_ctrl  = (paddr == rcts_pkg::ADDR_CTRL);
	wire a_stat  = (paddr == rcts_pkg::ADDR_STATUS);
	wire a_istat = (paddr == rcts_pkg::ADDR_INT_STAT);
	wire a_imask = (paddr == rcts_pkg::ADDR_INT_MASK);
	wire a_word  = (paddr == rcts_pkg::ADDR_OUT_WORD);
	wire mapped  = a_ctrl | a_stat | a_istat | a_imask | a_word;

	wire software_start_command = wr_acc & a_ctrl & pwdata[rcts_pkg::CTRL_START];
	wire software_reset_command = wr_acc & a_ctrl & pwdata[rcts_pkg::CTRL_RESET];
	wire sw_loaded              = wr_acc & a_ctrl & pwdata[rcts_pkg::CTRL_LOADED];

	////////////////////////////////////////////////////////////////////////////////
	// Run-control state machine
	rcts_pkg::rcts_state_type state_ff;
	rcts_pkg::rcts_state_type nxt_state;
	logic nxt_restart;
	logic nxt_resume;

	// Software start acts exactly like a pin edge
	wire start_evt = trig_fall | software_start_command;
	// Halt held low blocks any start
	wire halt_act  = ~halt_lvl;

	always_comb begin
		nxt_state   = state_ff;
		nxt_restart = 1'b0;
		nxt_resume  = 1'b0;
		case (state_ff)
			rcts_pkg::ST_RESET: begin
				if (sw_loaded) begin
					nxt_state = rcts_pkg::ST_HALTED;
				end
			end
			rcts_pkg::ST_RUNNING: begin
				if (halt_act || software_reset_command) begin
					nxt_state   = rcts_pkg::ST_HALTED;
					nxt_restart = 1'b1;
				end else if (seq_stop_hit) begin
					nxt_state = rcts_pkg::ST_STOPPED;
				end else if (seq_wait_hit) begin
					nxt_state = rcts_pkg::ST_WAITING;
				end
			end
			rcts_pkg::ST_WAITING: begin
				if (halt_act || software_reset_command) begin
					nxt_state   = rcts_pkg::ST_HALTED;
					nxt_restart = 1'b1;
				end else if (start_evt) begin
					nxt_state  = rcts_pkg::ST_RUNNING;
					nxt_resume = 1'b1;
				end
			end
			default: begin
				// Halted or stopped: next start runs from the top
				if (halt_act || software_reset_command) begin
					nxt_state   = rcts_pkg::ST_HALTED;
					nxt_restart = (state_ff == rcts_pkg::ST_STOPPED);
				end else if (start_evt) begin
					nxt_state   = rcts_pkg::ST_RUNNING;
					nxt_restart = 1'b1;
				end
			end
		endcase
	end

	// Flags follow the next state so they line up with state_ff
	wire nxt_stopped = (nxt_state == rcts_pkg::ST_STOPPED);
	wire nxt_reset_n = (nxt_state != rcts_pkg::ST_RESET);
	wire nxt_running = (nxt_state == rcts_pkg::ST_RUNNING);
	wire nxt_waiting = (nxt_state == rcts_pkg::ST_WAITING);

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			state_ff       <= rcts_pkg::ST_RESET;
			seq_restart    <= 1'b0;
			seq_resume     <= 1'b0;
			seq_run        <= 1'b0;
			status_stopped <= 1'b0;
			status_reset_n <= 1'b0;
			status_running <= 1'b0;
			status_waiting <= 1'b0;
		end else begin
			state_ff       <= nxt_state;
			seq_restart    <= nxt_restart;
			seq_resume     <= nxt_resume;
			seq_run        <= nxt_running;
			status_stopped <= nxt_stopped;
			status_reset_n <= nxt_reset_n;
			status_running <= nxt_running;
			status_waiting <= nxt_waiting;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Output word hold
	// Captured only at instruction start so bits cannot glitch mid-instruction
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			output_bits           <= rcts_pkg::WORD_RST;
			output_bits_low_group <= 4'h0;
		end else if (seq_word_load) begin
			output_bits           <= seq_word;
			output_bits_low_group <= seq_word[rcts_pkg::LOW_BITS-1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Interrupt status and mask
	logic [rcts_pkg::EVT_W-1:0] int_stat_ff;
	logic [rcts_pkg::EVT_W-1:0] int_mask_ff;
	wire  [rcts_pkg::EVT_W-1:0] evt = {start_evt, halt_fall,
		nxt_waiting & ~status_waiting, nxt_stopped & ~status_stopped};
	wire  [rcts_pkg::EVT_W-1:0] w1c = (wr_acc & a_istat) ? pwdata[rcts_pkg::EVT_W-1:0] : '0;
	// New events win over a same-cycle clear
	wire  [rcts_pkg::EVT_W-1:0] nxt_int_stat = (int_stat_ff & ~w1c) | evt;
	// Mask written in this access already counts, so irq never lags it
	wire  [rcts_pkg::EVT_W-1:0] nxt_int_mask = (wr_acc & a_imask) ?
		pwdata[rcts_pkg::EVT_W-1:0] : int_mask_ff;
	wire  nxt_irq = |(nxt_int_stat & nxt_int_mask);

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			int_stat_ff <= '0;
			int_mask_ff <= rcts_pkg::INT_MASK_RST;
			irq         <= 1'b0;
		end else begin
			int_stat_ff <= nxt_int_stat;
			int_mask_ff <= nxt_int_mask;
			irq         <= nxt_irq;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// APB answer: one wait state, read data registered with ready
	wire [31:0] stat_word = {26'h000_0000, halt_lvl, trig_lvl, status_waiting,
		status_running, status_reset_n, status_stopped};
	wire [31:0] rd_mux = a_stat  ? stat_word :
	                     a_istat ? {28'h000_0000, int_stat_ff} :
	                     a_imask ? {28'h000_0000, int_mask_ff} :
	                     a_word  ? 32'(output_bits) : 32'h0000_0000;
	wire nxt_pready = psel & penable & ~pready;

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= nxt_pready;
			pslverr <= nxt_pready & ~mapped;
			prdata  <= (nxt_pready & ~pwrite) ? rd_mux : 32'h0000_0000;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);

	chk_stop_flag: assert property (
		(state_ff == rcts_pkg::ST_RUNNING) && seq_stop_hit && halt_lvl
		&& !software_reset_command |=> status_stopped && !status_running)
		else $error("stop hit did not raise stopped");

	chk_reset_level: assert property (
		(state_ff == rcts_pkg::ST_RESET) == !status_reset_n)
		else $error("reset status disagrees with state");

	chk_running_lvl: assert property (
		status_running == (state_ff == rcts_pkg::ST_RUNNING) && seq_run == status_running)
		else $error("running status wrong");

	chk_wait_hold: assert property (
		status_waiting && !start_evt && halt_lvl && !software_reset_command
		|=> status_waiting)
		else $error("waiting dropped without trigger");

	chk_trig_start: assert property (
		(state_ff == rcts_pkg::ST_HALTED) && trig_fall && halt_lvl
		&& !software_reset_command |=> status_running && seq_restart)
		else $error("trigger did not start idle program");

	chk_wait_resume: assert property (
		status_waiting && start_evt && halt_lvl && !software_reset_command
		|=> seq_resume && !seq_restart && status_running)
		else $error("resume after wait wrong");

	chk_stop_restart: assert property (
		status_stopped && start_evt && halt_lvl && !software_reset_command
		|=> seq_restart && !seq_resume)
		else $error("restart after stop wrong");

	chk_halt_block: assert property (
		!halt_lvl |=> !status_running)
		else $error("ran while halt held low");

	chk_halt_rewind: assert property (
		status_running && !halt_lvl |=> seq_restart ##1 !seq_restart)
		else $error("halt did not rewind");

	chk_sw_start: assert property (
		(state_ff == rcts_pkg::ST_HALTED) && software_start_command && halt_lvl
		&& !software_reset_command |=> status_running)
		else $error("software start ignored");

	chk_low_bits: assert property (
		seq_word_load |=> output_bits_low_group == $past(seq_word[3:0]))
		else $error("dedicated bits wrong");

	chk_word_hold: assert property (
		!seq_word_load |=> $stable(output_bits))
		else $error("word changed mid-instruction");

	chk_tick_rate: assert property (
		seq_tick |=> !seq_tick [*3] ##1 seq_tick)
		else $error("reference tick rate wrong");

	chk_irq_level: assert property (
		irq == |(int_stat_ff & int_mask_ff))
		else $error("irq disagrees with status");
endmodule
`default_nettype wire

/* File: bench/rcts_src.sv */
`timescale 1ns/1ps
`default_nettype none
// Far-side trigger and halt source; pins idle high by pull-up
module rcts_src (
	input  wire logic       mclk,     // Unit clock
	input  wire logic       rst_b,    // Synchronous reset, low
	input  wire logic       go_start, // Request a trigger pulse
	input  wire logic       go_halt,  // Request a halt pulse
	input  wire logic [3:0] hold,     // Low time in cycles
	output logic            start_n,  // Trigger pin
	output logic            halt_n    // Halt pin
);
	logic [3:0] cnt_s_ff;
	logic [3:0] cnt_h_ff;

	// Low time is random but always beyond the synchroniser depth
	always @(posedge mclk) begin
		if (!rst_b) begin
			cnt_s_ff <= 4'h0;
			cnt_h_ff <= 4'h0;
		end else begin
			if (go_start) cnt_s_ff <= hold;
			else if (cnt_s_ff != 4'h0) cnt_s_ff <= cnt_s_ff - 4'h1;
			if (go_halt) cnt_h_ff <= hold;
			else if (cnt_h_ff != 4'h0) cnt_h_ff <= cnt_h_ff - 4'h1;
		end
	end
	// Released pins return to the pull-up level
	assign start_n = (cnt_s_ff == 4'h0);
	assign halt_n  = (cnt_h_ff == 4'h0);
endmodule
`default_nettype wire

/* File: bench/run_control_trigger_status_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin failures++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
module run_control_trigger_status_tb;
	logic        mclk, rst_b, psel, penable, pwrite, pready, pslverr, irq;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, seed_v;
	logic        stop_hit, wait_hit, word_load, seq_tick, seq_run, seq_restart, seq_resume;
	logic [23:0] word, output_bits, w;
	logic [3:0]  low_grp, hold;
	logic        s_stop, s_rst_n, s_run, s_wait, go_start, go_halt, start_n, halt_n;
	logic [32:0] expq[$];
	logic [32:0] e;
	int          failures, check_count, n_restart, n_resume, n_tick;
	logic [3:0]  sts;

	assign sts = {s_wait, s_run, s_rst_n, s_stop};

	rcts_top i_dut (.mclk(mclk), .rst_b(rst_b), .external_start_in_n(start_n),
		.external_halt_in_n(halt_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.irq(irq), .seq_stop_hit(stop_hit), .seq_wait_hit(wait_hit), .seq_word_load(word_load),
		.seq_word(word), .seq_tick(seq_tick), .seq_run(seq_run), .seq_restart(seq_restart),
		.seq_resume(seq_resume), .output_bits(output_bits), .output_bits_low_group(low_grp),
		.status_stopped(s_stop), .status_reset_n(s_rst_n), .status_running(s_run),
		.status_waiting(s_wait));
	rcts_src i_src (.mclk(mclk), .rst_b(rst_b), .go_start(go_start), .go_halt(go_halt),
		.hold(hold), .start_n(start_n), .halt_n(halt_n));

	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end

	////////////////////////////////////////////////////////////////////////
	// Scoreboard and pulse counters
	always @(posedge mclk) begin
		if (psel && penable && pready === 1'b1) begin
			e = expq.pop_front();
			`CHK({pslverr, prdata}, e)
		end
		if (seq_restart === 1'b1) n_restart++;
		if (seq_resume === 1'b1) n_resume++;
		if (seq_tick === 1'b1) n_tick++;
	end

	task results;
		$display("failures=%0d checks=%0d", failures, check_count);
		if (failures == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [32:0] x);
		int i;
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		expq.push_back(x);
		@(posedge mclk);
		penable <= 1'b1;
		for (i = 0; i < 20 && pready !== 1'b1; i++) @(posedge mclk);
		if (i == 20) begin
			failures++;
			results;
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task wait_st(input int sel, input logic v);
		int i;
		for (i = 0; i < 40 && sts[sel] !== v; i++) @(posedge mclk);
		if (i == 40) begin
			failures++;
			results;
		end
		@(posedge mclk);
		#1;
	endtask

	task pin(input logic h);
		int i;
		@(posedge mclk);
		go_halt <= h;
		go_start <= !h;
		hold <= 4'(4 + $urandom % 5);
		@(posedge mclk);
		go_halt <= 1'b0;
		go_start <= 1'b0;
		// Pin only drops after this edge; wait for its release from here
		@(posedge mclk);
		for (i = 0; i < 20 && !(start_n && halt_n); i++) @(posedge mclk);
		if (i == 20) begin
			failures++;
			results;
		end
		repeat (6) @(posedge mclk);
		#1;
	endtask

	task core(input int k);
		@(posedge mclk);
		stop_hit <= (k == 0);
		wait_hit <= (k == 1);
		word_load <= (k == 2);
		@(posedge mclk);
		{stop_hit, wait_hit, word_load} <= 3'b000;
		word <= ~word;
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		{rst_b, psel, penable, pwrite, stop_hit, wait_hit, word_load, go_start, go_halt} = 9'h000;
		{paddr, pwdata, word, hold} = 68'h0;
		{failures, check_count, n_restart, n_resume} = 0;
		seed_v = $urandom(34544);
		repeat (2) @(posedge mclk);
		rst_b <= 1'b1;
		@(posedge mclk);
		#1;
		`CHK({s_wait, s_run, s_rst_n, s_stop}, 4'b0000)
		apb(0, rcts_pkg::ADDR_STATUS, 0, 33'h0_0000_0030);
		apb(0, 8'h14, 0, 33'h1_0000_0000);
		apb(0, rcts_pkg::ADDR_INT_MASK, 0, 33'h0);
		apb(1, rcts_pkg::ADDR_CTRL, 32'h0000_0004, 33'h0);
		wait_st(1, 1'b1);
		`CHK({s_wait, s_run, s_rst_n, s_stop}, 4'b0010)
		pin(1'b0);
		wait_st(2, 1'b1);
		`CHK({n_restart, seq_run, irq}, {32'd1, 1'b1, 1'b0})
		apb(1, rcts_pkg::ADDR_INT_MASK, 32'h0000_000F, 33'h0);
		apb(0, rcts_pkg::ADDR_INT_STAT, 0, 33'h0_0000_0008);
		`CHK(irq, 1'b1)
		apb(1, rcts_pkg::ADDR_INT_STAT, 32'h0000_0008, 33'h0);
		@(posedge mclk);
		#1;
		`CHK(irq, 1'b0)
		w = 24'($urandom);
		word <= w;
		core(2);
		repeat (5) core(3);
		`CHK({output_bits, low_grp}, {w, w[3:0]})
		apb(0, rcts_pkg::ADDR_OUT_WORD, 0, {9'h0, w});
		pin(1'b0);
		`CHK(n_restart, 1)
		core(1);
		wait_st(3, 1'b1);
		`CHK({s_wait, s_run, s_rst_n, s_stop, irq}, 5'b10101)
		apb(1, rcts_pkg::ADDR_CTRL, 32'h0000_0001, 33'h0);
		wait_st(2, 1'b1);
		`CHK({n_resume, n_restart, s_wait}, {32'd1, 32'd1, 1'b0})
		core(0);
		wait_st(0, 1'b1);
		`CHK({s_wait, s_run, s_rst_n, s_stop}, 4'b0011)
		pin(1'b1);
		`CHK({s_stop, s_rst_n, n_restart}, {2'b01, 32'd2})
		pin(1'b0);
		wait_st(2, 1'b1);
		`CHK(n_restart, 3)
		apb(1, rcts_pkg::ADDR_INT_STAT, 32'h0000_000F, 33'h0);
		pin(1'b1);
		wait_st(2, 1'b0);
		`CHK({seq_run, n_restart}, {1'b0, 32'd4})
		apb(0, rcts_pkg::ADDR_INT_STAT, 0, 33'h0_0000_0004);
		apb(1, rcts_pkg::ADDR_CTRL, 32'h0000_0001, 33'h0);
		wait_st(2, 1'b1);
		`CHK(n_restart, 5)
		apb(1, rcts_pkg::ADDR_CTRL, 32'h0000_0002, 33'h0);
		wait_st(2, 1'b0);
		apb(0, rcts_pkg::ADDR_STATUS, 0, 33'h0_0000_0032);
		#1;
		n_tick = 0;
		repeat (40) @(posedge mclk);
		#1;
		`CHK(n_tick, 10)
		results;
	end
endmodule
`default_nettype wire
